//--- inc/lcs_pkg.sv
// Constants, register map and state codes of the line contactor sequencer.
// Assumes a single 200 MHz core clock and an AXI4-Lite register bus.
//
// How it works
// - Command bit routed to chosen digital outputs
// - Contactor closes shortly before motor is energised
// - After off, hold contactor for holding time
// - Default feedback is the own command bit
// - Monitored feedback is an inverted digital input
// - Fault when feedback misses the monitoring time
// - Safe torque off opens now or after holding
package lcs_pkg;
    // ==========================================================
    // Clock and time
    localparam int unsigned CLK_FREQ_HZ = 200_000_000;
    localparam int unsigned MS_PER_S = 1000;
    // Cycles in one millisecond, derived from the clock rate
    localparam int unsigned CYCLES_PER_MS = CLK_FREQ_HZ / MS_PER_S;
    localparam logic [15:0] HOLD_TIME_MS = 16'h0032;
    localparam logic [15:0] MON_TIME_MS = 16'h0064;
    // Lead of the contactor ahead of the motor
    localparam logic [15:0] LEAD_TIME_MS = 16'h0001;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_HOLD = 8'h04;
    localparam logic [7:0] ADDR_MON = 8'h08;
    localparam logic [7:0] ADDR_ROUTE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    // ==========================================================
    // Field positions
    localparam int CFG_MON_EN = 0;
    localparam int CFG_SEL_LSB = 1;
    localparam int CFG_STO_SEQ = 8;
    localparam int STAT_CMD = 0;
    localparam int STAT_FB = 1;
    localparam int STAT_MOTOR = 2;
    localparam int STAT_STATE_LSB = 4;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_CLOSED = 1;
    localparam int IRQ_OPENED = 2;
    localparam int IRQ_W = 3;
    // ==========================================================
    // Reset values
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [31:0] ROUTE_RST = 32'h0000_0000;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Sequencer states
    typedef enum logic [1:0] {
        ST_OPEN = 2'b00,
        ST_CLOSING = 2'b01,
        ST_RUNNING = 2'b10,
        ST_HOLDING = 2'b11
    } seq_state_t;
endpackage

//--- logic/lcs_sync2.sv
// Two-flop synchroniser for pin inputs.
// Assumes the inputs are slow levels, not multi-bit words.
`timescale 1ns/1ps
`default_nettype none
module lcs_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Asynchronous levels
    input wire logic [W-1:0] i_async,
    // Synchronised levels
    output logic [W-1:0] o_sync
);
    // First stage, read only by the second
    logic [W-1:0] meta_reg;

    // ==========================================================
    // Two stages
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_reg <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_reg <= i_async;
            o_sync <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- logic/lcs_ms_timer.sv
// Millisecond one-shot timer with its own prescaler.
// Assumes start and stop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lcs_ms_timer #(
    parameter int unsigned CYCLES_PER_MS = lcs_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Control
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [15:0] i_load_ms,
    // State
    output logic o_busy,
    output logic o_expired
);
    // Milliseconds left and cycles within the current one
    logic [15:0] ms_reg;
    logic [31:0] cyc_reg;
    wire last_cyc = (cyc_reg == 32'(CYCLES_PER_MS - 1));
    wire done = (ms_reg == 16'h0000) ||
        (last_cyc && (ms_reg == 16'h0001));

    // ==========================================================
    // Prescaler restarts with each start, so timing is exact
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ms_reg <= 16'h0000;
            cyc_reg <= 32'h0000_0000;
            o_busy <= 1'b0;
            o_expired <= 1'b0;
        end
        else
        begin
            o_expired <= 1'b0;
            if (i_start)
            begin
                ms_reg <= i_load_ms;
                cyc_reg <= 32'h0000_0000;
                o_busy <= 1'b1;
            end
            else if (i_stop)
                o_busy <= 1'b0;
            else if (o_busy && done)
            begin
                o_busy <= 1'b0;
                o_expired <= 1'b1;
            end
            else if (o_busy && last_cyc)
            begin
                cyc_reg <= 32'h0000_0000;
                ms_reg <= ms_reg - 16'h0001;
            end
            else if (o_busy)
                cyc_reg <= cyc_reg + 32'h0000_0001;
        end
    end
endmodule
`default_nettype wire

//--- logic/lcs_top.sv
// Line contactor sequencer with AXI4-Lite registers and interrupt.
// Assumes run request from logic on this clock; stop and inputs are pins.
`timescale 1ns/1ps
`default_nettype none
module lcs_top #(
    parameter int NDO = 4,
    parameter int NDI = 8,
    parameter int unsigned CYCLES_PER_MS = lcs_pkg::CYCLES_PER_MS
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // AXI4-Lite write address
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [7:0] i_awaddr,
    // AXI4-Lite write data
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    // AXI4-Lite write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read address
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [7:0] i_araddr,
    // AXI4-Lite read data
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // Drive control
    input wire logic i_run_request,
    input wire logic i_safe_torque_off,
    input wire logic [NDI-1:0] i_feedback_digital_input,
    // Contactor and motor
    output logic o_contactor_command_bit,
    output logic [NDO-1:0] o_digital_output,
    output logic o_motor_enable,
    output logic o_contactor_feedback_fault,
    output logic o_irq
);
    localparam int SW = $clog2(NDI);

    // ==========================================================
    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] wmerge(input logic [31:0] old,
        input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++)
            if (strb[b])
                r[8*b +: 8] = data[8*b +: 8];
        return r;
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic sto_sync; // Safe torque off, synchronised
    logic [NDI-1:0] din_sync; // Feedback inputs, synchronised
    lcs_sync2 #(.W(1)) u_sync_sto (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_safe_torque_off),
        .o_sync(sto_sync)
    );
    lcs_sync2 #(.W(NDI)) u_sync_din (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async(i_feedback_digital_input),
        .o_sync(din_sync)
    );

    // ==========================================================
    // Register storage
    logic [15:0] cfg_reg; // Monitor enable, input select, stop mode
    logic [15:0] hold_reg; // Off holding time in ms
    logic [15:0] mon_reg; // Feedback monitoring time in ms
    logic [NDO-1:0] route_reg; // Outputs carrying the command
    logic [2:0] irq_stat_reg; // Sticky events
    logic [2:0] irq_mask_reg; // Event enables
    lcs_pkg::seq_state_t state_reg;
    lcs_pkg::seq_state_t state_next;

    // Configuration fields
    wire mon_en = cfg_reg[lcs_pkg::CFG_MON_EN];
    wire [SW-1:0] fb_sel = cfg_reg[lcs_pkg::CFG_SEL_LSB +: SW];
    wire sto_seq = cfg_reg[lcs_pkg::CFG_STO_SEQ];
    wire fault = irq_stat_reg[lcs_pkg::IRQ_FAULT];

    // ==========================================================
    // Write channel: address and data taken in either order
    logic aw_held_reg; // Address captured, awaiting data
    logic w_held_reg; // Data captured, awaiting address
    logic [7:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    wire aw_fire = i_awvalid && o_awready;
    wire w_fire = i_wvalid && o_wready;
    wire [7:0] wa = aw_fire ? i_awaddr : waddr_reg;
    wire [31:0] wd = w_fire ? i_wdata : wdata_reg;
    wire [3:0] ws = w_fire ? i_wstrb : wstrb_reg;
    wire wr_go = (aw_held_reg || aw_fire) && (w_held_reg || w_fire);

    // Write address decode
    wire wr_cfg = wr_go && (wa == lcs_pkg::ADDR_CONFIG);
    wire wr_hold = wr_go && (wa == lcs_pkg::ADDR_HOLD);
    wire wr_mon = wr_go && (wa == lcs_pkg::ADDR_MON);
    wire wr_route = wr_go && (wa == lcs_pkg::ADDR_ROUTE);
    wire wr_stat = wr_go && (wa == lcs_pkg::ADDR_IRQ_STAT);
    wire wr_mask = wr_go && (wa == lcs_pkg::ADDR_IRQ_MASK);
    wire wr_ro = wr_go && (wa == lcs_pkg::ADDR_STATUS);
    wire wr_ok = wr_cfg || wr_hold || wr_mon || wr_route ||
        wr_stat || wr_mask || wr_ro;

    // Merged values for the writable words
    wire [31:0] cfg_m = wmerge({16'h0000, cfg_reg}, wd, ws);
    wire [31:0] hold_m = wmerge({16'h0000, hold_reg}, wd, ws);
    wire [31:0] mon_m = wmerge({16'h0000, mon_reg}, wd, ws);
    wire [31:0] route_m = wmerge(32'(route_reg), wd, ws);
    wire [31:0] mask_m = wmerge({29'h0, irq_mask_reg}, wd, ws);
    wire [31:0] clr_m = wmerge(32'h0, wd, ws);

    // Handshake state for the write side
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            waddr_reg <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= lcs_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_fire)
                waddr_reg <= i_awaddr;
            if (w_fire)
            begin
                wdata_reg <= i_wdata;
                wstrb_reg <= i_wstrb;
            end
            // A half that waits is held until its partner arrives
            aw_held_reg <= (aw_held_reg || aw_fire) && !wr_go;
            w_held_reg <= (w_held_reg || w_fire) && !wr_go;
            if (wr_go)
            begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_ok ? lcs_pkg::RESP_OKAY
                    : lcs_pkg::RESP_SLVERR;
            end
            else if (i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Ready only when that half is free and no answer is pending
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
        end
        else
        begin
            o_awready <= !(aw_held_reg || aw_fire) || wr_go ? 
                !wr_go && !o_bvalid && !(aw_held_reg || aw_fire) : 1'b0;
            o_wready <= !(w_held_reg || w_fire) || wr_go ?
                !wr_go && !o_bvalid && !(w_held_reg || w_fire) : 1'b0;
        end
    end

    // ==========================================================
    // Read channel
    wire feedback_w; // Selected contactor feedback
    wire ar_fire = i_arvalid && o_arready;
    wire [31:0] status_w = 32'({state_reg, 1'b0, o_motor_enable,
        1'b0, o_contactor_command_bit}) |
        (32'(feedback_w) << lcs_pkg::STAT_FB);
    wire rd_hit = (i_araddr == lcs_pkg::ADDR_CONFIG) ||
        (i_araddr == lcs_pkg::ADDR_HOLD) ||
        (i_araddr == lcs_pkg::ADDR_MON) ||
        (i_araddr == lcs_pkg::ADDR_ROUTE) ||
        (i_araddr == lcs_pkg::ADDR_STATUS) ||
        (i_araddr == lcs_pkg::ADDR_IRQ_STAT) ||
        (i_araddr == lcs_pkg::ADDR_IRQ_MASK);
    wire [31:0] rd_w =
        (i_araddr == lcs_pkg::ADDR_CONFIG) ? {16'h0000, cfg_reg} :
        (i_araddr == lcs_pkg::ADDR_HOLD) ? {16'h0000, hold_reg} :
        (i_araddr == lcs_pkg::ADDR_MON) ? {16'h0000, mon_reg} :
        (i_araddr == lcs_pkg::ADDR_ROUTE) ? 32'(route_reg) :
        (i_araddr == lcs_pkg::ADDR_STATUS) ? status_w :
        (i_araddr == lcs_pkg::ADDR_IRQ_STAT) ? {29'h0, irq_stat_reg} :
        (i_araddr == lcs_pkg::ADDR_IRQ_MASK) ? {29'h0, irq_mask_reg} :
        32'h0000_0000;

    // One read at a time; unmapped reads answer zero with an error
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= lcs_pkg::RESP_OKAY;
        end
        else
        begin
            o_arready <= !o_rvalid && !ar_fire && !o_arready;
            if (ar_fire)
            begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_w;
                o_rresp <= rd_hit ? lcs_pkg::RESP_OKAY
                    : lcs_pkg::RESP_SLVERR;
            end
            else if (i_rready)
                o_rvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Feedback choice: own command, or an inverted input pin
    assign feedback_w = mon_en ? !din_sync[fb_sel]
        : o_contactor_command_bit;

    // ==========================================================
    // Timers
    logic seq_busy;
    logic seq_exp; // Lead or holding time has run out
    logic mon_busy;
    logic mon_exp; // Monitoring time has run out
    wire seq_start = (state_next != state_reg) &&
        ((state_next == lcs_pkg::ST_CLOSING) ||
        (state_next == lcs_pkg::ST_HOLDING));
    wire seq_stop = (state_next == lcs_pkg::ST_OPEN) ||
        (state_next == lcs_pkg::ST_RUNNING);
    wire [15:0] seq_load = (state_next == lcs_pkg::ST_CLOSING) ?
        lcs_pkg::LEAD_TIME_MS : hold_reg;
    wire cmd_next = (state_next != lcs_pkg::ST_OPEN);
    wire cmd_change = (cmd_next != o_contactor_command_bit);
    // Restart on every change, stop once feedback agrees
    wire mon_start = cmd_change;
    wire fb_match = (feedback_w == o_contactor_command_bit);
    wire mon_stop = mon_busy && fb_match;
    // Fault only while the contactor still disagrees
    wire fault_set = mon_exp && mon_en && !fb_match;

    lcs_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_seq_timer (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_start(seq_start),
        .i_stop(seq_stop),
        .i_load_ms(seq_load),
        .o_busy(seq_busy),
        .o_expired(seq_exp)
    );
    lcs_ms_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_mon_timer (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_start(mon_start),
        .i_stop(mon_stop),
        .i_load_ms(mon_reg),
        .o_busy(mon_busy),
        .o_expired(mon_exp)
    );

    // ==========================================================
    // Sequencer decisions
    wire sto_now = sto_sync && !sto_seq; // Open at once
    wire run_ok = i_run_request && !sto_sync && !fault;
    wire cut = fault || sto_now || fault_set;

    // Next state; a pending fault blocks closing again
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            lcs_pkg::ST_OPEN:
                if (run_ok && !fault_set)
                    state_next = lcs_pkg::ST_CLOSING;
            lcs_pkg::ST_CLOSING:
                if (cut)
                    state_next = lcs_pkg::ST_OPEN;
                else if (!run_ok)
                    state_next = lcs_pkg::ST_HOLDING;
                else if (seq_exp)
                    state_next = lcs_pkg::ST_RUNNING;
            lcs_pkg::ST_RUNNING:
                if (cut)
                    state_next = lcs_pkg::ST_OPEN;
                else if (!run_ok)
                    state_next = lcs_pkg::ST_HOLDING;
            lcs_pkg::ST_HOLDING:
                // Expiry beats a fresh run request in the same cycle
                if (cut || seq_exp)
                    state_next = lcs_pkg::ST_OPEN;
                else if (run_ok)
                    state_next = lcs_pkg::ST_RUNNING;
            default:
                state_next = lcs_pkg::ST_OPEN;
        endcase
    end

    // Command, routed outputs and motor enable, all registered
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= lcs_pkg::ST_OPEN;
            o_contactor_command_bit <= 1'b0;
            o_digital_output <= '0;
            o_motor_enable <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            o_contactor_command_bit <= cmd_next;
            o_digital_output <= route_reg & {NDO{cmd_next}};
            o_motor_enable <= (state_next == lcs_pkg::ST_RUNNING);
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cfg_reg <= lcs_pkg::CONFIG_RST;
            hold_reg <= lcs_pkg::HOLD_TIME_MS;
            mon_reg <= lcs_pkg::MON_TIME_MS;
            route_reg <= lcs_pkg::ROUTE_RST[NDO-1:0];
            irq_mask_reg <= lcs_pkg::IRQ_MASK_RST;
        end
        else
        begin
            if (wr_cfg)
                cfg_reg <= cfg_m[15:0];
            if (wr_hold)
                hold_reg <= hold_m[15:0];
            if (wr_mon)
                mon_reg <= mon_m[15:0];
            if (wr_route)
                route_reg <= route_m[NDO-1:0];
            if (wr_mask)
                irq_mask_reg <= mask_m[2:0];
        end
    end

    // ==========================================================
    // Interrupts: new events win over a clear in the same cycle
    wire [2:0] irq_set = {o_contactor_command_bit && !cmd_next,
        !o_contactor_command_bit && cmd_next, fault_set};
    wire [2:0] irq_clr = wr_stat ? clr_m[2:0] : 3'h0;
    wire [2:0] irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            irq_stat_reg <= 3'h0;
            o_irq <= 1'b0;
            o_contactor_feedback_fault <= 1'b0;
        end
        else
        begin
            irq_stat_reg <= irq_stat_next;
            o_irq <= |(irq_stat_next & irq_mask_reg);
            o_contactor_feedback_fault <= irq_stat_next[0];
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_mismatch_timeout;
        mon_exp && mon_en && !fb_match;
    endsequence
    sequence s_cmd_change;
        cmd_change;
    endsequence

    a_route_output: assert property (1 |=>
        o_digital_output == ($past(route_reg) &
        {NDO{o_contactor_command_bit}}))
        else $error("routed outputs disagree with command");
    a_motor_needs_cmd: assert property (
        o_motor_enable |-> o_contactor_command_bit)
        else $error("motor enabled with contactor open");
    a_open_first: assert property (
        $rose(o_contactor_command_bit) |-> !o_motor_enable)
        else $error("motor not preceded by contactor");
    a_hold_keeps_cmd: assert property (
        (state_reg == lcs_pkg::ST_HOLDING) && !seq_exp && !cut
        |=> o_contactor_command_bit)
        else $error("contactor dropped during holding");
    a_fb_internal: assert property (
        !mon_en |-> feedback_w == o_contactor_command_bit)
        else $error("feedback not tied to own command");
    a_fb_inverted: assert property (
        mon_en |-> feedback_w == !din_sync[fb_sel])
        else $error("feedback not inverted input");
    a_fault_raise: assert property (s_mismatch_timeout
        |=> irq_stat_reg[0] && o_contactor_feedback_fault)
        else $error("missing contactor fault");
    a_sto_immediate: assert property (
        sto_sync && !sto_seq |=> !o_contactor_command_bit)
        else $error("stop did not open contactor");
    a_sto_delayed: assert property (
        sto_sync && sto_seq && !fault && !fault_set &&
        (state_reg == lcs_pkg::ST_RUNNING)
        |=> (state_reg == lcs_pkg::ST_HOLDING) && o_contactor_command_bit)
        else $error("delayed stop did not hold");
    a_mon_restart: assert property (s_cmd_change
        |=> mon_busy)
        else $error("monitor not restarted");
    a_mon_stop: assert property (
        mon_busy && fb_match && !cmd_change |=> !mon_busy)
        else $error("monitor kept running on match");
endmodule
`default_nettype wire

//--- bench/lcs_contactor_model.sv
// Line contactor with an auxiliary contact.
// Assumes the contact pin feeds a feedback input.
`timescale 1ns/1ps
`default_nettype none
module lcs_contactor_model #(
    parameter int DLY = 4
) (
    // Clock, coil and fault injection
    input wire logic i_core_clk,
    input wire logic i_coil,
    input wire logic i_stuck,
    // Contact, low while closed
    output logic o_aux_n
);
    // ==========================================
    // Armature lag; a stuck contact never closes
    logic [DLY-1:0] lag_reg = '0;
    always_ff @(posedge i_core_clk)
    begin
        lag_reg <= {lag_reg[DLY-2:0], i_coil};
    end
    assign o_aux_n = i_stuck | ~lag_reg[DLY-1];
endmodule
`default_nettype wire

//--- bench/lcs_top_tb.sv
// Bench for the line contactor sequencer.
// Assumes ten cycles per millisecond.
`timescale 1ns/1ps
`default_nettype none
module lcs_top_tb;
    logic i_core_clk = 0, i_rstn = 0, i_awvalid = 0, i_wvalid = 0;
    logic i_bready = 0, i_arvalid = 0, i_rready = 0, i_run_request = 0;
    logic i_safe_torque_off = 0, stuck = 1, aux_n;
    logic [7:0] i_awaddr = 0, i_araddr = 0, i_feedback_digital_input;
    logic [31:0] i_wdata = 0, o_rdata;
    logic [3:0] i_wstrb = 4'hf, o_digital_output;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic o_contactor_command_bit, o_motor_enable, o_contactor_feedback_fault;
    logic [1:0] o_bresp, o_rresp;
    int checks = 0, mismatches = 0;
    // Row: address, read data, response
    logic [41:0] rows [6] = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h32, 2'h0},
        {8'h08, 32'h64, 2'h0}, {8'h0c, 32'h0, 2'h0}, {8'h18, 32'h0, 2'h0},
        {8'h1c, 32'h0, 2'h2}};
    assign i_feedback_digital_input = {7'h00, aux_n};
    lcs_top #(.CYCLES_PER_MS(10)) lcs_top_inst (.i_core_clk, .i_rstn,
        .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
        .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
        .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_run_request,
        .i_safe_torque_off, .i_feedback_digital_input,
        .o_contactor_command_bit, .o_digital_output, .o_motor_enable,
        .o_contactor_feedback_fault, .o_irq);
    lcs_contactor_model lcs_contactor_model_inst (.i_core_clk,
        .i_coil(o_digital_output[2]), .i_stuck(stuck), .o_aux_n(aux_n));
    initial
    begin
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Both halves offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        do
        begin
            @(posedge i_core_clk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
        end while (o_bvalid !== 1);
        // The write must be answered OKAY
        chk(o_bresp, 0);
    endtask
    task automatic rd(input logic [41:0] r);
        i_araddr <= r[41:34];
        i_arvalid <= 1;
        i_rready <= 1;
        do
        begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 0;
        end while (o_rvalid !== 1);
        chk(o_rdata, r[33:2]);
        chk(o_rresp, r[1:0]);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask
    initial
    begin
        cyc(5);
        i_rstn <= 1;
        foreach (rows[k]) rd(rows[k]);
        wr(8'h04, 5);
        wr(8'h0c, 4);
        wr(8'h18, 7);
        i_run_request <= 1;
        cyc(2);
        chk({o_contactor_command_bit, o_motor_enable}, 2);
        chk(o_digital_output, 4);
        cyc(15);
        chk(o_motor_enable, 1);
        rd({8'h10, 32'h27, 2'h0});
        i_run_request <= 0;
        cyc(40);
        chk({o_contactor_command_bit, o_motor_enable}, 2);
        cyc(20);
        chk(o_digital_output, 0);
        chk({o_contactor_feedback_fault, o_irq}, 1);
        wr(8'h14, 7);
        rd({8'h14, 34'h0});
        for (int s = 0; s < 2; s++)
        begin
            wr(8'h00, s << 8);
            i_run_request <= 1;
            cyc(15);
            i_safe_torque_off <= 1;
            cyc(40);
            chk(o_contactor_command_bit, s);
            cyc(20);
            chk(o_contactor_command_bit, 0);
            i_safe_torque_off <= 0;
            i_run_request <= 0;
            cyc(3);
        end
        wr(8'h08, 2);
        wr(8'h00, 1);
        stuck <= 0;
        i_run_request <= 1;
        cyc(40);
        i_run_request <= 0;
        cyc(80);
        chk(o_contactor_feedback_fault, 0);
        stuck <= 1;
        i_run_request <= 1;
        cyc(40);
        chk({o_contactor_feedback_fault, o_contactor_command_bit}, 2);
        i_run_request <= 0;
        wr(8'h14, 7);
        cyc(3);
        chk({o_contactor_feedback_fault, o_irq}, 0);
        i_rstn <= 0;
        cyc(2);
        chk({o_awready, o_irq, o_contactor_command_bit}, 0);
        i_rstn <= 1;
        rd({8'h04, 32'h32, 2'h0});
        report_and_stop();
    end
    initial
    begin
        cyc(20000);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire
